// ---- design/irq_consts.svh ----
// constants for the modem interrupt aggregator: offsets, bit positions, reset values
//
// What this block does
// [R1] thirteen interrupt sources, each with its own status flag in registers
// [R2] one interrupt output, active low, always driven in both states
// [R3] each source has its own mask bit gating the shared output
// [R4] output low whenever any unmasked flag is set, an OR of sources
// [R5] global mask bit blocks every source from the output
// [R6] flags cleared only by writing 1; writing 0 leaves them alone
// [R7] reading status registers never changes any flag
// [R8] a set flag stays set until software clears it
// [R9] output is level sensitive, held until flags cleared or masked
// [R10] synthesizer loss-of-lock sets the unlock flag
// [R11] filter reject follows selected network, or AND of both on shared channel
// [R12] rx level flag sets when byte count reaches programmed threshold
// [R13] channel assessment completion sets its flag
// [R14] receive completion sets receive done flag
// [R15] transmit completion sets transmit done flag
// [R16] sequence done sets on every non-idle to idle transition
// [R17] buffer underrun flag sets only in burst access mode
// [R18] wake flag sets on power-on or deep sleep wake; indicator tells which
// [R19] timer flags one, three, four set on counter equal compare
// [R20] timer two flag sets on 24-bit or 16-bit alternate match
// [R21] event in same cycle as clear wins; flag ends set
// [R22] flags set regardless of their mask bits
// [R23] after reset all flags clear and output high
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

`define NUM_SRC 13
`define NUM_TMR 4

// ==========================================
// flag bit positions in status and mask, field positions in control
`define FLG_UNLOCK 0
`define FLG_FILTER 1
`define FLG_LEVEL 2
`define FLG_CCA 3
`define FLG_RXDONE 4
`define FLG_TXDONE 5
`define FLG_SEQ 6
`define FLG_UNDERRUN 7
`define FLG_WAKE 8
`define FLG_TMR1 9
`define FLG_TMR2 10
`define FLG_TMR3 11
`define FLG_TMR4 12
`define WAKE_TYPE_BIT 13
`define GLOBAL_MASK_BIT 16
`define CTRL_TMR_EN_LSB 0
`define CTRL_ALT_EN_BIT 4
`define CTRL_NET_SEL_BIT 5
`define CTRL_THR_LSB 8

// ==========================================
// register byte offsets
`define OFS_STATUS 8'h00
`define OFS_MASK 8'h04
`define OFS_CTRL 8'h08
`define OFS_CMP1 8'h0C
`define OFS_CMP2 8'h10
`define OFS_CMP2ALT 8'h14
`define OFS_CMP3 8'h18
`define OFS_CMP4 8'h1C

// ==========================================
// reset values and bus answers
`define CMP_RST 24'h000FFF
`define CMP_ALT_RST 16'h00FF
`define THR_RST 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- design/irq_pkg.sv ----
// types shared by the modem interrupt aggregator
package irq_pkg;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_t;

    // modem event sources; single-bit ones are pulses unless noted
    typedef struct packed {
        logic synth_unlock;
        logic filter_valid;
        logic network_zero_reject;
        logic network_one_reject;
        logic dual_network;   // level
        logic shared_channel; // level
        logic rx_byte_strobe;
        logic [7:0] rx_byte_count;
        logic cca_done;
        logic rx_done;
        logic tx_done;
        logic seq_idle;       // level
        logic buffer_underrun;
        logic burst_mode;     // level
        logic wake_por;
        logic wake_deep_sleep;
        logic [23:0] event_timer;
    } modem_evt_t;

    typedef struct packed {
        logic [12:0] flag;
        logic wake_from_sleep;
        logic [12:0] mask;
        logic global_mask;
        logic [3:0] tmr_en;
        logic alt_en;
        logic net_sel;
        logic [7:0] level_thr;
        logic [3:0][23:0] cmp;
        logic [15:0] cmp_alt;
        logic seq_idle_d;
        logic irq_n;
        logic have_aw;
        logic have_w;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        axi_rsp_t rsp;
    } state_t;

endpackage

// ---- design/timer_match.sv ----
// one event timer comparator giving a pulse when the count first equals the compare value
`timescale 1ns/10ps
module timer_match #(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [WIDTH-1:0] count,
    input wire logic [WIDTH-1:0] compare,
    output logic hit
);
    logic eq;
    logic eq_reg;

    assign eq = enable && (count == compare);
    // a slow timer holds its value for many clocks; fire only once per match
    assign hit = eq && !eq_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eq_reg <= 1'b0;
        end else begin
            eq_reg <= eq;
        end
    end
endmodule

// ---- design/modem_interrupt_aggregator.sv ----
// modem interrupt aggregator: sticky flags, masks, timer compares and an AXI4-Lite register slave
`timescale 1ns/10ps
`include "irq_consts.svh"
module modem_interrupt_aggregator (
    input wire logic clk,
    input wire logic sys_rst,
    input wire irq_pkg::axi_req_t axi_req,
    output irq_pkg::axi_rsp_t axi_rsp,
    input wire irq_pkg::modem_evt_t evt,
    output logic irq_n,
    output logic [`NUM_SRC-1:0] flag_status
);
    import irq_pkg::*;

    state_t s_reg;
    state_t s_next;

    logic [`NUM_TMR-1:0] tmr_hit;
    logic alt_hit;
    logic [`NUM_SRC-1:0] set_v;
    logic [`NUM_SRC-1:0] clr_v;
    logic filter_fail;
    logic seq_done;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] wr_bits;
    logic [3:0] wr_strb;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;

    // ==========================================
    // event timer comparators
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_TMR; gi++) begin : g_tmr
            timer_match #(.WIDTH(24)) u_match (
                .clk(clk),
                .sys_rst(sys_rst),
                .enable(s_reg.tmr_en[gi]),
                .count(evt.event_timer),
                .compare(s_reg.cmp[gi]),
                .hit(tmr_hit[gi])
            );
        end
    endgenerate

    // alternate compare looks only at the low 16 bits of the 24-bit timer
    timer_match #(.WIDTH(16)) u_alt_match (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(s_reg.tmr_en[1] && s_reg.alt_en),
        .count(evt.event_timer[15:0]),
        .compare(s_reg.cmp_alt),
        .hit(alt_hit)
    );

    // ==========================================
    // event decode
    always_comb begin
        filter_fail = 1'b0;
        if (evt.filter_valid) begin
            if (evt.dual_network && evt.shared_channel) begin
                filter_fail = evt.network_zero_reject && evt.network_one_reject; // [R11]
            end else if (evt.dual_network && s_reg.net_sel) begin
                filter_fail = evt.network_one_reject; // [R11]
            end else begin
                filter_fail = evt.network_zero_reject; // [R11]
            end
        end
    end

    assign seq_done = evt.seq_idle && !s_reg.seq_idle_d; // [R16]

    // sources set their flag whatever the mask says [R22]
    always_comb begin
        set_v = '0;
        set_v[`FLG_UNLOCK] = evt.synth_unlock; // [R10]
        set_v[`FLG_FILTER] = filter_fail; // [R11]
        set_v[`FLG_LEVEL] = evt.rx_byte_strobe && (evt.rx_byte_count == s_reg.level_thr); // [R12]
        set_v[`FLG_CCA] = evt.cca_done; // [R13]
        set_v[`FLG_RXDONE] = evt.rx_done; // [R14]
        set_v[`FLG_TXDONE] = evt.tx_done; // [R15]
        set_v[`FLG_SEQ] = seq_done; // [R16]
        set_v[`FLG_UNDERRUN] = evt.buffer_underrun && evt.burst_mode; // [R17]
        set_v[`FLG_WAKE] = evt.wake_por || evt.wake_deep_sleep; // [R18]
        set_v[`FLG_TMR1] = tmr_hit[0]; // [R19]
        set_v[`FLG_TMR2] = tmr_hit[1] || alt_hit; // [R20]
        set_v[`FLG_TMR3] = tmr_hit[2]; // [R19]
        set_v[`FLG_TMR4] = tmr_hit[3]; // [R19]
    end

    // ==========================================
    // bus handshakes
    assign aw_fire = axi_req.awvalid && s_reg.rsp.awready;
    assign w_fire = axi_req.wvalid && s_reg.rsp.wready;
    assign ar_fire = axi_req.arvalid && s_reg.rsp.arready;
    assign wr_fire = (s_reg.have_aw || aw_fire) && (s_reg.have_w || w_fire) && !s_reg.rsp.bvalid;
    assign wr_addr = s_reg.have_aw ? s_reg.waddr : axi_req.awaddr;
    assign wr_data = s_reg.have_w ? s_reg.wdata : axi_req.wdata;
    assign wr_strb = s_reg.have_w ? s_reg.wstrb : axi_req.wstrb;

    // byte enables widened to a bit mask
    always_comb begin
        wr_bits = '0;
        for (int i = 0; i < 4; i++) begin
            wr_bits[8*i +: 8] = {8{wr_strb[i]}};
        end
    end

    assign wr_ok = (wr_addr[1:0] == 2'h0) && (wr_addr <= `OFS_CMP4);

    // write-1 clears only through the status word, with its byte lanes [R6]
    assign clr_v = (wr_fire && wr_addr == `OFS_STATUS) ? (wr_data[`NUM_SRC-1:0] & wr_bits[`NUM_SRC-1:0]) : '0;

    // ==========================================
    // read mux; pure, so reads leave every flag alone [R7]
    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        unique case (axi_req.araddr)
            `OFS_STATUS: begin
                rd_data[`NUM_SRC-1:0] = s_reg.flag;
                // the wake type only means something while the wake flag is up [R18]
                rd_data[`WAKE_TYPE_BIT] = s_reg.wake_from_sleep && s_reg.flag[`FLG_WAKE];
            end
            `OFS_MASK: begin
                rd_data[`NUM_SRC-1:0] = s_reg.mask;
                rd_data[`GLOBAL_MASK_BIT] = s_reg.global_mask;
            end
            `OFS_CTRL: begin
                rd_data[`CTRL_TMR_EN_LSB +: `NUM_TMR] = s_reg.tmr_en;
                rd_data[`CTRL_ALT_EN_BIT] = s_reg.alt_en;
                rd_data[`CTRL_NET_SEL_BIT] = s_reg.net_sel;
                rd_data[`CTRL_THR_LSB +: 8] = s_reg.level_thr;
            end
            `OFS_CMP1: rd_data[23:0] = s_reg.cmp[0];
            `OFS_CMP2: rd_data[23:0] = s_reg.cmp[1];
            `OFS_CMP2ALT: rd_data[15:0] = s_reg.cmp_alt;
            `OFS_CMP3: rd_data[23:0] = s_reg.cmp[2];
            `OFS_CMP4: rd_data[23:0] = s_reg.cmp[3];
            default: rd_ok = 1'b0;
        endcase
    end

    // ==========================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.seq_idle_d = evt.seq_idle;

        // set beats a coincident clear [R21], and only a write clears [R8]
        s_next.flag = (s_reg.flag & ~clr_v) | set_v; // [R6] [R8] [R21]
        if (evt.wake_por || evt.wake_deep_sleep) begin
            s_next.wake_from_sleep = evt.wake_deep_sleep; // [R18]
        end

        if (wr_fire && wr_ok) begin
            unique case (wr_addr)
                `OFS_MASK: begin
                    s_next.mask = (s_reg.mask & ~wr_bits[`NUM_SRC-1:0]) | (wr_data[`NUM_SRC-1:0] & wr_bits[`NUM_SRC-1:0]);
                    if (wr_strb[2]) begin
                        s_next.global_mask = wr_data[`GLOBAL_MASK_BIT];
                    end
                end
                `OFS_CTRL: begin
                    if (wr_strb[0]) begin
                        s_next.tmr_en = wr_data[`CTRL_TMR_EN_LSB +: `NUM_TMR];
                        s_next.alt_en = wr_data[`CTRL_ALT_EN_BIT];
                        s_next.net_sel = wr_data[`CTRL_NET_SEL_BIT];
                    end
                    if (wr_strb[1]) begin
                        s_next.level_thr = wr_data[`CTRL_THR_LSB +: 8];
                    end
                end
                `OFS_CMP1: s_next.cmp[0] = (s_reg.cmp[0] & ~wr_bits[23:0]) | (wr_data[23:0] & wr_bits[23:0]);
                `OFS_CMP2: s_next.cmp[1] = (s_reg.cmp[1] & ~wr_bits[23:0]) | (wr_data[23:0] & wr_bits[23:0]);
                `OFS_CMP2ALT: s_next.cmp_alt = (s_reg.cmp_alt & ~wr_bits[15:0]) | (wr_data[15:0] & wr_bits[15:0]);
                `OFS_CMP3: s_next.cmp[2] = (s_reg.cmp[2] & ~wr_bits[23:0]) | (wr_data[23:0] & wr_bits[23:0]);
                `OFS_CMP4: s_next.cmp[3] = (s_reg.cmp[3] & ~wr_bits[23:0]) | (wr_data[23:0] & wr_bits[23:0]);
                default: begin
                end
            endcase
        end

        // line follows the next flags so it moves with them, from a flop [R2] [R9]
        s_next.irq_n = !((|(s_next.flag & ~s_next.mask)) && !s_next.global_mask); // [R3] [R4] [R5] [R9]

        // write channel: hold whichever half came first until the other arrives
        if (wr_fire) begin
            s_next.have_aw = 1'b0;
            s_next.have_w = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else begin
            if (aw_fire) begin
                s_next.have_aw = 1'b1;
                s_next.waddr = axi_req.awaddr;
            end
            if (w_fire) begin
                s_next.have_w = 1'b1;
                s_next.wdata = axi_req.wdata;
                s_next.wstrb = axi_req.wstrb;
            end
        end
        if (s_reg.rsp.bvalid && axi_req.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end
        s_next.rsp.awready = !s_next.have_aw && !s_next.rsp.bvalid;
        s_next.rsp.wready = !s_next.have_w && !s_next.rsp.bvalid;

        // read channel: one read in flight
        if (ar_fire) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rdata = rd_data;
            s_next.rsp.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_reg.rsp.rvalid && axi_req.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end
        s_next.rsp.arready = !s_next.rsp.rvalid;
    end

    // ==========================================
    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.flag <= '0; // [R23]
            s_reg.irq_n <= 1'b1; // [R23]
            s_reg.level_thr <= `THR_RST;
            s_reg.cmp <= {`NUM_TMR{`CMP_RST}};
            s_reg.cmp_alt <= `CMP_ALT_RST;
            s_reg.seq_idle_d <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign axi_rsp = s_reg.rsp;
    assign irq_n = s_reg.irq_n;
    assign flag_status = s_reg.flag;

    // ==========================================
    // assertions
    localparam int RSP_MIN = 1;
    localparam int RSP_MAX = 1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence wr_both_taken;
        wr_fire;
    endsequence

    sequence wr_answered;
        s_reg.rsp.bvalid && !s_reg.rsp.awready && !s_reg.rsp.wready;
    endsequence

    a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) // [R23]
        sys_rst |=> (s_reg.flag == '0) && s_reg.irq_n)
        else $error("flags or line not idle after reset");

    a_line_matches_flags: assert property ( // [R4]
        s_reg.irq_n == !((|(s_reg.flag & ~s_reg.mask)) && !s_reg.global_mask))
        else $error("interrupt line disagrees with flags and masks");

    a_global_blocks_line: assert property ( // [R5]
        s_reg.global_mask |-> s_reg.irq_n)
        else $error("line asserted under global mask");

    a_set_beats_clear: assert property ( // [R21]
        ((set_v & clr_v) != '0) |=>
            ((s_reg.flag & $past(set_v) & $past(clr_v)) == ($past(set_v) & $past(clr_v))))
        else $error("coincident clear won over event");

    a_flag_sticky: assert property ( // [R8]
        1'b1 |=> ((($past(s_reg.flag) & ~$past(clr_v)) & ~s_reg.flag) == '0))
        else $error("flag fell without a write-1 clear");

    a_read_no_clear: assert property ( // [R7]
        (ar_fire && !wr_fire) |=> ((($past(s_reg.flag)) & ~s_reg.flag) == '0))
        else $error("read changed a flag");

    a_seq_done_flag: assert property ( // [R16]
        (evt.seq_idle && !s_reg.seq_idle_d) |=> s_reg.flag[`FLG_SEQ])
        else $error("idle entry did not set sequence flag");

    a_underrun_gate: assert property ( // [R17]
        (!s_reg.flag[`FLG_UNDERRUN] && !evt.burst_mode) |=> !s_reg.flag[`FLG_UNDERRUN])
        else $error("underrun flag set outside burst mode");

    a_wake_type: assert property ( // [R18]
        (evt.wake_deep_sleep && !evt.wake_por) |=> s_reg.flag[`FLG_WAKE] && s_reg.wake_from_sleep)
        else $error("deep sleep wake not reported");

    a_timer_two_alt: assert property ( // [R20]
        alt_hit |=> s_reg.flag[`FLG_TMR2])
        else $error("alternate compare did not set timer two flag");

    a_write_answer: assert property (
        wr_both_taken |-> ##[RSP_MIN:RSP_MAX] wr_answered)
        else $error("write not answered in one cycle");

    a_unlock_sets: assert property ( // [R10]
        evt.synth_unlock |=> s_reg.flag[`FLG_UNLOCK])
        else $error("loss of lock did not set unlock flag");

    a_filter_sets: assert property ( // [R11]
        filter_fail |=> s_reg.flag[`FLG_FILTER])
        else $error("filter reject did not set its flag");

    a_level_sets: assert property ( // [R12]
        (evt.rx_byte_strobe && (evt.rx_byte_count == s_reg.level_thr)) |=> s_reg.flag[`FLG_LEVEL])
        else $error("rx level reached without flag");

    a_cca_sets: assert property ( // [R13]
        evt.cca_done |=> s_reg.flag[`FLG_CCA])
        else $error("channel assessment done did not set flag");

    a_rx_done_sets: assert property ( // [R14]
        evt.rx_done |=> s_reg.flag[`FLG_RXDONE])
        else $error("receive done did not set flag");

    a_tx_done_sets: assert property ( // [R15]
        evt.tx_done |=> s_reg.flag[`FLG_TXDONE])
        else $error("transmit done did not set flag");

    a_timer_one_sets: assert property ( // [R19]
        tmr_hit[0] |=> s_reg.flag[`FLG_TMR1])
        else $error("timer one match did not set flag");

    a_mask_gates_line: assert property ( // [R3]
        ((s_reg.flag & ~s_reg.mask) == '0) |-> s_reg.irq_n)
        else $error("line asserted with every set flag masked");

    a_clear_takes: assert property ( // [R6]
        ((clr_v & ~set_v) != '0) |=> ((s_reg.flag & $past(clr_v) & ~$past(set_v)) == '0))
        else $error("write-1 clear left a flag set");

endmodule

// ---- verif/host_irq_monitor.sv ----
// host side model: watches the interrupt line and counts each new assertion
`timescale 1ns/10ps
module host_irq_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irq_n,
    output logic [7:0] irq_seen
);
    logic irq_n_d;

    // the line is a level, so the host counts a falling level once, not every low cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_n_d <= 1'b1;
            irq_seen <= 8'h00;
        end else begin
            irq_n_d <= irq_n;
            if (irq_n_d && !irq_n) begin
                irq_seen <= irq_seen + 8'h01;
            end
        end
    end
endmodule

// ---- verif/modem_interrupt_aggregator_tb.sv ----
// self-checking bench for the modem interrupt aggregator
`timescale 1ns/10ps
`include "irq_consts.svh"
module modem_interrupt_aggregator_tb;
    import irq_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    axi_req_t req;
    axi_rsp_t rsp;
    modem_evt_t ev_r;
    modem_evt_t base;
    modem_evt_t evt_w;
    logic [23:0] tmr;
    logic irq_n;
    logic [12:0] flags;
    logic [7:0] irq_seen;
    logic [33:0] exp_q[$];
    logic [7:0] cofs[4] = '{`OFS_CMP1, `OFS_CMP2, `OFS_CMP3, `OFS_CMP4};
    int mismatches = 0;
    int samples_checked = 0;

    // timer count is steered on its own so event pulses never disturb it
    assign evt_w = {ev_r[$bits(modem_evt_t)-1:24], tmr};

    modem_interrupt_aggregator dut (.clk(clk), .sys_rst(sys_rst), .axi_req(req), .axi_rsp(rsp),
        .evt(evt_w), .irq_n(irq_n), .flag_status(flags));
    host_irq_monitor host (.clk(clk), .sys_rst(sys_rst), .irq_n(irq_n), .irq_seen(irq_seen));

    always #10 clk = ~clk;

    // ==========================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (rsp.rvalid && req.rready) begin
            chk("read response", {30'h0, exp_q[0][33:32]}, {30'h0, rsp.rresp});
            chk("read data", exp_q[0][31:0], rsp.rdata);
            void'(exp_q.pop_front());
        end
    end

    // bready and rready stay high, so a response is taken the edge it shows
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        chk("write response", {30'h0, er}, {30'h0, rsp.bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
        exp_q.push_back({er, d});
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
    endtask

    task automatic ev(input modem_evt_t e);
        ev_r <= e;
        @(posedge clk);
        ev_r <= base;
        @(posedge clk);
    endtask

    function automatic modem_evt_t mk(input int i);
        modem_evt_t e;
        e = base;
        case (i)
            0: e.synth_unlock = 1'b1;
            1: {e.filter_valid, e.network_zero_reject} = 2'b11;
            2: {e.rx_byte_strobe, e.rx_byte_count} = {1'b1, `THR_RST};
            3: e.cca_done = 1'b1;
            4: e.rx_done = 1'b1;
            5: e.tx_done = 1'b1;
            6: e.seq_idle = 1'b1;
            7: {e.buffer_underrun, e.burst_mode} = 2'b11;
            default: e.wake_deep_sleep = 1'b1;
        endcase
        return e;
    endfunction

    // ==========================================
    // scenarios
    initial begin
        int m;
        logic [7:0] seen0;
        modem_evt_t neg;
        base = '0;
        ev_r = '0;
        tmr = 24'h0;
        req = '0;
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        req.rready = 1'b1;
        void'($urandom(32'h50cf));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        chk("flags after reset", 32'h0, {19'h0, flags});
        chk("irq after reset", 32'h1, {31'h0, irq_n});
        rd(`OFS_MASK, 32'h0);
        rd(`OFS_CTRL, {16'h0, `THR_RST, 8'h00});
        rd(`OFS_CMP1, {8'h0, `CMP_RST});
        rd(`OFS_CMP2ALT, {16'h0, `CMP_ALT_RST});
        for (int i = 0; i < 9; i++) begin
            seen0 = irq_seen;
            ev(mk(i));
            chk("flag set", 32'h1 << i, {19'h0, flags});
            chk("irq asserted", 32'h0, {31'h0, irq_n});
            repeat (3) @(posedge clk);
            wr(`OFS_STATUS, 32'h0);
            rd(`OFS_STATUS, (32'h1 << i) | (i == 8 ? 32'h1 << `WAKE_TYPE_BIT : 32'h0));
            rd(`OFS_STATUS, (32'h1 << i) | (i == 8 ? 32'h1 << `WAKE_TYPE_BIT : 32'h0));
            wr(`OFS_STATUS, 32'h1 << i);
            chk("flag cleared", 32'h0, {19'h0, flags});
            chk("irq released", 32'h1, {31'h0, irq_n});
            chk("host saw one assertion", {24'h0, seen0 + 8'h01}, {24'h0, irq_seen});
        end
        neg = base;
        neg.buffer_underrun = 1'b1;
        ev(neg);
        neg = mk(2);
        neg.rx_byte_count = 8'hFE;
        ev(neg);
        base.dual_network = 1'b1;
        base.shared_channel = 1'b1;
        ev(mk(1));
        chk("no flag on refused events", 32'h0, {19'h0, flags});
        neg = mk(1);
        neg.network_one_reject = 1'b1;
        ev(neg);
        chk("shared channel reject", 32'h1 << `FLG_FILTER, {19'h0, flags});
        wr(`OFS_STATUS, 32'h1FFF);
        base.shared_channel = 1'b0;
        wr(`OFS_CTRL, 32'h0000FF20);
        ev(mk(1));
        chk("unselected network", 32'h0, {19'h0, flags});
        neg = base;
        {neg.filter_valid, neg.network_one_reject} = 2'b11;
        ev(neg);
        chk("selected network", 32'h1 << `FLG_FILTER, {19'h0, flags});
        wr(`OFS_STATUS, 32'h1FFF);
        base.dual_network = 1'b0;
        for (int r = 0; r < 3; r++) begin
            m = $urandom();
            wr(`OFS_MASK, m & 32'h1FFF);
            for (int i = 0; i < 9; i++) ev(mk(i));
            chk("flags under mask", 32'h1FF, {19'h0, flags});
            chk("irq under mask", {31'h0, ((~m) & 32'h1FF) == 32'h0}, {31'h0, irq_n});
            wr(`OFS_MASK, (m & 32'h1FFF) | (32'h1 << `GLOBAL_MASK_BIT));
            chk("irq global mask", 32'h1, {31'h0, irq_n});
            wr(`OFS_STATUS, 32'h1FFF);
            chk("all cleared", 32'h0, {19'h0, flags});
        end
        neg = base;
        neg.wake_por = 1'b1;
        ev(neg);
        rd(`OFS_STATUS, 32'h1 << `FLG_WAKE);
        wr(`OFS_STATUS, 32'h1FFF);
        wr(`OFS_MASK, 32'h0);
        wr(`OFS_CMP2ALT, 32'h0505);
        wr(`OFS_CTRL, 32'h0000FF1F);
        tmr <= 24'h120505;
        repeat (3) @(posedge clk);
        chk("alt compare flag", 32'h1 << `FLG_TMR2, {19'h0, flags});
        wr(`OFS_STATUS, 32'h1FFF);
        for (int k = 0; k < 4; k++) begin
            wr(cofs[k], 32'h000101 * (k + 1));
            tmr <= 24'(32'h000101 * (k + 1));
            repeat (3) @(posedge clk);
            chk("timer flag", 32'h1 << (`FLG_TMR1 + k), {19'h0, flags});
            wr(`OFS_STATUS, 32'h1FFF);
        end
        // event held through the clearing write; look on the answer edge, before a later event could set it again
        ev_r <= mk(3);
        wr(`OFS_STATUS, 32'h1 << `FLG_CCA);
        chk("event beats clear", 32'h1 << `FLG_CCA, {19'h0, flags});
        ev_r <= base;
        @(posedge clk);
        wr(8'h20, 32'hFFFFFFFF, `RESP_SLVERR);
        rd(8'h20, 32'h0, `RESP_SLVERR);
        rd(8'h06, 32'h0, `RESP_SLVERR);
        wr(`OFS_MASK, 32'h1FFF);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        chk("flags after second reset", 32'h0, {19'h0, flags});
        chk("irq after second reset", 32'h1, {31'h0, irq_n});
        rd(`OFS_MASK, 32'h0);
        repeat (2) @(posedge clk);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule
